// ===== src/srctl_pkg.sv
// Purpose: constants and types for the host-side async SRAM access controller
// Assumes: 100 MHz clk_sys, 16K x 1 SRAM with separate data in and data out
// Notes:   times in ns, cycle counts derived from the clock period
package srctl_pkg;
	localparam int CLK_PERIOD_NS       = 10;
	localparam int ADDR_W              = 14;
	// Minimum times round up, maximum times round down, at least one cycle
	function automatic int srctl_min_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int srctl_max_cyc(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	// Slowest speed grade figures
	localparam int ACCESS_NS                    = 55;
	localparam int READ_CYCLE_NS                = 50;
	localparam int WRITE_PULSE_NS               = 25;
	localparam int SELECT_TO_END_NS             = 45;
	localparam int DATA_SETUP_NS                = 20;
	localparam int WRITE_CYCLE_NS               = 50;
	localparam int STROBE_TO_OUTPUT_OFF_DELAY_NS = 25;
	localparam int DISABLE_TO_FLOAT_NS          = 25;
	localparam int RETENTION_DESELECT_LEAD_NS   = 0;
	localparam int RETENTION_RECOVERY_TIME_NS   = READ_CYCLE_NS;
	localparam int ACCESS_CYC   = srctl_min_cyc(ACCESS_NS);
	localparam int WPULSE_CYC   = srctl_min_cyc(SELECT_TO_END_NS);
	localparam int WOFF_CYC     = srctl_min_cyc(STROBE_TO_OUTPUT_OFF_DELAY_NS);
	localparam int FLOAT_CYC    = srctl_min_cyc(DISABLE_TO_FLOAT_NS);
	localparam int RECOVERY_CYC = srctl_min_cyc(RETENTION_RECOVERY_TIME_NS);
	localparam int CNT_W        = 4;
	typedef enum logic [2:0] {
		SRCTL_IDLE,
		SRCTL_READ,
		SRCTL_WSETUP,
		SRCTL_WPULSE,
		SRCTL_WEND,
		SRCTL_GAP,
		SRCTL_RETAIN,
		SRCTL_RECOVER
	} srctl_state_type;
endpackage

// ===== src/srctl_if.sv
// Purpose: timer request and expiry between controller and its timer
// Assumes: single clock domain
// Notes:   load starts a count, done pulses when it runs out
`timescale 1ns/1ns
`default_nettype none
interface srctl_tmr_if;
	import srctl_pkg::*;
	logic             load;
	logic [CNT_W-1:0] count;
	logic             done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ===== src/srctl_timer.sv
// Purpose: down counter that marks when a timed phase has elapsed
// Assumes: count of at least one
// Notes:   done pulses one cycle, count plus one cycles after the cycle with load high
`timescale 1ns/1ns
`default_nettype none
module srctl_timer
	import srctl_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	srctl_tmr_if.tmr  t
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             run;
		logic             done;
	} srctl_tmr_type;
	srctl_tmr_type r_q, r_d;
	always_comb begin
		r_d      = r_q;
		r_d.done = 1'b0;
		if (t.load) begin
			r_d.cnt = t.count - CNT_W'(1);
			r_d.run = 1'b1;
		end else if (r_q.run) begin
			if (r_q.cnt == '0) begin
				r_d.run  = 1'b0;
				r_d.done = 1'b1;
			end else begin
				r_d.cnt = r_q.cnt - CNT_W'(1);
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
	assign t.done = r_q.done;
endmodule
`default_nettype wire

// ===== src/srctl_host.sv
// Purpose: host controller driving a 16K x 1 asynchronous SRAM by its pins
// Assumes: SRAM data input and output are separate pins; inputs synchronous
// Notes:   one request at a time; retention mode parks select high
// Functional notes
// - Reads keep write strobe high throughout
// - Do not drive shared bus early in write
// - Strobe-ended write: setup and hold met
// - Select-ended write: setup, hold; output floats
// - Select or strobe high while address changes
`timescale 1ns/1ns
`default_nettype none
module srctl_host
	import srctl_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic          req_wdata,
	input  wire logic          retain_req,
	output logic               req_ready,
	output logic               rsp_valid,
	output logic               rsp_rdata,
	output logic               retained,
	output logic               sel_n,
	output logic               wr_n,
	output logic [AW-1:0]      cell_index_lines,
	output logic               din,
	input  wire logic          dout
);
	typedef struct packed {
		srctl_state_type  st;
		logic             ready;
		logic             rsp;
		logic             rdata;
		logic             ret;
		logic             sel_n;
		logic             wr_n;
		logic [AW-1:0]    addr;
		logic             din;
	} srctl_host_type;
	srctl_host_type r_q, r_d;
	srctl_tmr_if tif ();
	srctl_timer u_timer (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.t       (tif.tmr)
	);
	always_comb begin
		r_d       = r_q;
		r_d.rsp   = 1'b0;
		tif.load  = 1'b0;
		tif.count = '0;
		case (r_q.st)
			SRCTL_IDLE: begin
				if (retain_req) begin
					// Deselect before supply drops, lead of zero
					r_d.sel_n = 1'b1;
					r_d.wr_n  = 1'b1;
					r_d.ready = 1'b0;
					r_d.ret   = 1'b1;
					r_d.st    = SRCTL_RETAIN;
				end else if (req_valid && r_q.ready) begin
					// Address changes only while the write strobe is high; a read drops select in the same cycle
					r_d.addr  = req_addr;
					r_d.din   = req_wdata;
					r_d.ready = 1'b0;
					r_d.st    = req_write ? SRCTL_WSETUP : SRCTL_READ;
					if (!req_write) begin
						r_d.sel_n = 1'b0;
						r_d.wr_n  = 1'b1;
						tif.load  = 1'b1;
						tif.count = CNT_W'(ACCESS_CYC);
					end
				end
			end
			SRCTL_READ: begin
				if (tif.done) begin
					r_d.rdata = dout;
					r_d.rsp   = 1'b1;
					r_d.sel_n = 1'b1;
					r_d.st    = SRCTL_GAP;
					tif.load  = 1'b1;
					tif.count = CNT_W'(FLOAT_CYC);
				end
			end
			SRCTL_WSETUP: begin
				// Strobe and select fall together, so the output never turns on
				r_d.wr_n  = 1'b0;
				r_d.sel_n = 1'b0;
				r_d.st    = SRCTL_WPULSE;
				tif.load  = 1'b1;
				tif.count = CNT_W'(WPULSE_CYC);
			end
			SRCTL_WPULSE: begin
				if (tif.done) begin
					// Select rise ends the write; data held past it
					r_d.sel_n = 1'b1;
					r_d.st    = SRCTL_WEND;
				end
			end
			SRCTL_WEND: begin
				// Strobe released one cycle after select: hold met
				r_d.wr_n  = 1'b1;
				r_d.rsp   = 1'b1;
				r_d.st    = SRCTL_GAP;
				tif.load  = 1'b1;
				tif.count = CNT_W'(WOFF_CYC);
			end
			SRCTL_GAP: begin
				if (tif.done) begin
					r_d.ready = 1'b1;
					r_d.st    = SRCTL_IDLE;
				end
			end
			SRCTL_RETAIN: begin
				if (!retain_req) begin
					r_d.st    = SRCTL_RECOVER;
					tif.load  = 1'b1;
					tif.count = CNT_W'(RECOVERY_CYC);
				end
			end
			SRCTL_RECOVER: begin
				if (tif.done) begin
					r_d.ret   = 1'b0;
					r_d.ready = 1'b1;
					r_d.st    = SRCTL_IDLE;
				end
			end
			default: begin
				r_d.st = SRCTL_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_q       <= '0;
			r_q.st    <= SRCTL_IDLE;
			r_q.sel_n <= 1'b1;
			r_q.wr_n  <= 1'b1;
			r_q.ready <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end
	assign req_ready        = r_q.ready;
	assign rsp_valid        = r_q.rsp;
	assign rsp_rdata        = r_q.rdata;
	assign retained         = r_q.ret;
	assign sel_n            = r_q.sel_n;
	assign wr_n             = r_q.wr_n;
	assign cell_index_lines = r_q.addr;
	assign din              = r_q.din;
endmodule
`default_nettype wire

// ===== sim/srctl_sram_model.sv
// Purpose: 16K x 1 async SRAM model
// Assumes: separate data in and out
// Notes:   released output shows inverse of last value
`timescale 1ns/1ns
`default_nettype none
module srctl_sram_model #(parameter int ACC_NS = 0) (
	input  wire logic        sel_n,
	input  wire logic        wr_n,
	input  wire logic [13:0] cell_index_lines,
	input  wire logic        din,
	output logic             dout
);
	logic mem [16384];
	logic val;
	logic last = 1'h0;
	logic on;
	assign #(ACC_NS) val = mem[cell_index_lines];
	assign on = !sel_n && wr_n;
	always @(sel_n, wr_n, cell_index_lines, din)
		if (!sel_n && !wr_n)
			mem[cell_index_lines] = din;
	always @(on, val)
		if (on)
			last = val;
	assign dout = on ? val : ~last;
endmodule
`default_nettype wire

// ===== sim/srctl_checker.sv
// Purpose: pin timing checks
// Assumes: hand-over cycle walk
// Notes:   bound to srctl_host
`timescale 1ns/1ns
`default_nettype none
module srctl_checker
	import srctl_pkg::*;
#(parameter int AW = ADDR_W) (
	input wire logic          clk_sys,
	input wire logic          rstn,
	input wire logic          req_valid,
	input wire logic [AW-1:0] req_addr,
	input wire logic          retain_req,
	input wire logic          req_ready,
	input wire logic          rsp_valid,
	input wire logic          rsp_rdata,
	input wire logic          retained,
	input wire logic          sel_n,
	input wire logic          wr_n,
	input wire logic [AW-1:0] cell_index_lines,
	input wire logic          din,
	input wire logic          dout
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence rd_go; $fell(sel_n) && wr_n; endsequence
	sequence wr_go; $fell(sel_n) && !wr_n; endsequence
	rd_hold_a: assert property (rd_go |-> (!sel_n && wr_n)[*7] ##1 sel_n) else $error("read hold");
	rd_data_a: assert property (rd_go |-> ##7 rsp_valid && rsp_rdata == $past(dout)) else $error("read data");
	wr_pulse_a: assert property (wr_go |-> (!sel_n && !wr_n)[*6] ##1 sel_n ##1 (wr_n && rsp_valid))
		else $error("write pulse");
	wr_din_a: assert property (!wr_n && !$past(wr_n) |-> $stable(din)) else $error("din moved");
	addr_hold_a: assert property (!sel_n && !$past(sel_n) |-> $stable(cell_index_lines)) else $error("addr moved");
	wr_late_a: assert property ($fell(wr_n) |-> $fell(sel_n)) else $error("late strobe");
	take_addr_a: assert property (req_ready && req_valid && !retain_req |=> cell_index_lines == $past(req_addr))
		else $error("take addr");
	retain_sel_a: assert property (retained |-> sel_n && wr_n) else $error("retain select");
endmodule
bind srctl_host srctl_checker #(.AW(AW)) u_chk (.*);
`default_nettype wire

// ===== sim/test_srctl_host.sv
// Purpose: bench for srctl_host
// Assumes: model answers in 50 ns
// Notes:   table rows, then retention
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %0h got %0h", s, e, g); end end
module test_srctl_host import srctl_pkg::*;;
	typedef struct packed {logic w; logic [13:0] a; logic d; logic [3:0] lat;} srctl_row_type;
	logic          clk_sys = 1'h0;
	logic          rstn = 1'h0;
	logic          req_valid = 1'h0;
	logic          req_write = 1'h0;
	logic          req_wdata = 1'h0;
	logic          retain_req = 1'h0;
	logic [13:0]   req_addr = 14'h0;
	logic          req_ready, rsp_valid, rsp_rdata, retained, sel_n, wr_n, din, dout, r;
	logic [13:0]   cell_index_lines;
	int            mismatches = 0;
	int            n_checks = 0;
	int            n;
	srctl_row_type rows [8] = '{'{1'h1, 14'h0, 1'h1, 4'h8}, '{1'h1, 14'h3FFF, 1'h1, 4'h8},
		'{1'h1, 14'h1555, 1'h0, 4'h8}, '{1'h0, 14'h0, 1'h1, 4'h7}, '{1'h0, 14'h3FFF, 1'h1, 4'h7},
		'{1'h0, 14'h1555, 1'h0, 4'h7}, '{1'h1, 14'h0, 1'h0, 4'h8}, '{1'h0, 14'h0, 1'h0, 4'h7}};
	srctl_host u_dut (.*);
	srctl_sram_model #(.ACC_NS(50)) u_mem (.*);
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wait_rsp;
		n = 0;
		while (rsp_valid !== 1'h1 && n < 20) begin
			@(posedge clk_sys) #1;
			n++;
		end
		r = rsp_rdata;
	endtask
	task automatic xfer(input logic w, input logic [13:0] a, input logic d);
		while (req_ready !== 1'h1)
			@(posedge clk_sys) #1;
		{req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
		@(posedge clk_sys) #1 req_valid = 1'h0;
		wait_rsp();
	endtask
	initial begin
		#30000;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK("sel_n", 1'h1, sel_n)
		rstn = 1'h1;
		foreach (rows[i]) begin
			xfer(rows[i].w, rows[i].a, rows[i].d);
			`CHK("latency", rows[i].lat, n[3:0])
			if (!rows[i].w)
				`CHK("rdata", rows[i].d, r)
		end
		{retain_req, req_valid, req_write, req_addr} = {1'h1, 1'h1, 1'h0, 14'h3FFF};
		repeat (6) @(posedge clk_sys);
		#1;
		`CHK("retained", 2'h3, {retained, sel_n})
		retain_req = 1'h0;
		n = 0;
		while (sel_n !== 1'h0 && n < 20) begin
			@(posedge clk_sys) #1;
			n++;
		end
		req_valid = 1'h0;
		`CHK("recovery", 1'h1, n > 4 && n < 20)
		wait_rsp();
		`CHK("kept rsp", 1'h1, rsp_valid)
		`CHK("kept data", 1'h1, r)
		summarize();
	end
endmodule
`default_nettype wire
